// ===== src/fault_flags_pkg.sv
// constants for the port fault status flag registers
package fault_flags_pkg;
    // register offsets
    localparam logic [7:0] PORT1_STATUS_OFFSET = 8'h03;
    localparam logic [7:0] PORT2_STATUS_OFFSET = 8'h04;
    // port 1 status field positions
    localparam int P1_ERROR_BIT      = 7;
    localparam int P1_BACKBIAS_BIT   = 1;
    localparam int P1_OVERCURR_BIT   = 0;
    // port 2 status field positions
    localparam int P2_ERROR_BIT      = 7;
    localparam int P2_DISCHARGE_BIT  = 6;
    localparam int P2_UNDERVOLT_BIT  = 5;
    localparam int P2_MINVOLT_BIT    = 4;
    localparam int P2_THERMAL_BIT    = 3;
    localparam int P2_BACKBIAS_BIT   = 1;
    localparam int P2_OVERCURR_BIT   = 0;
    // reset value of both status registers
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // back-bias margin above source or device supply, in millivolts
    localparam int BACKBIAS_MARGIN_MV = 150;
    // controller state
    typedef enum logic {ST_ACTIVE, ST_ERROR} port_state_t;
endpackage

// ===== src/sticky_fault_bit.sv
// one sticky fault flag, set by its condition, cleared by read or error clear
`timescale 1ns/1ps
`default_nettype none
module sticky_fault_bit (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic fault_cond,
    input  wire logic read_clear,
    input  wire logic error_clear,
    output logic      flag
);
    typedef struct packed {
        logic flag;
    } cell_state_t;

    cell_state_t state_reg;
    cell_state_t state_next;

    // a live condition holds or sets the flag, beating any clear
    always_comb
    begin
        state_next      = state_reg;
        state_next.flag = fault_cond | (state_reg.flag & ~read_clear & ~error_clear);
    end

    // state register
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign flag = state_reg.flag;
endmodule
`default_nettype wire

// ===== src/port_fault_status_flags.sv
// port fault status flag registers, alert outputs and error state
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - back-bias flag: bus above either supply plus 150 mV
// - overcurrent flag needs both current thresholds exceeded
// - read clears gone faults; error clear clears all but the thermal and live undervoltage flags
// - any port 1 flag asserts alert, enters error
// - alert pin independent of port 1 error flag
module port_fault_status_flags #(
    parameter int MV_W = 13,
    parameter int MA_W = 13
) (
    input  wire logic            clk_sys,
    input  wire logic            sys_rst,
    input  wire logic [7:0]      reg_addr,
    input  wire logic            reg_rd,
    input  wire logic            reg_wr,
    input  wire logic [7:0]      reg_wdata,
    output logic [7:0]           reg_rdata,
    input  wire logic [MV_W-1:0] port1_bus_mv,
    input  wire logic [MV_W-1:0] source_mv,
    input  wire logic [MV_W-1:0] device_mv,
    input  wire logic [MA_W-1:0] port1_current_ma,
    input  wire logic [MA_W-1:0] programmed_current_limit,
    input  wire logic [MA_W-1:0] secondary_min_current_threshold,
    input  wire logic            port2_discharge_cond,
    input  wire logic            source_undervoltage_flag,
    input  wire logic            port2_min_voltage_cond,
    input  wire logic            thermal_regulation_cond,
    input  wire logic            port2_backbias_cond,
    input  wire logic            port2_overcurrent_cond,
    output logic                 port1_alert_n,
    output logic                 port2_alert_n,
    output logic                 port1_error_flag,
    output logic                 port2_error_flag,
    output logic                 port1_in_error
);
    // refuse widths that cannot hold the back-bias margin or the current compares
    if (MV_W < 8 || MA_W < 4)
    begin
        $error("port_fault_status_flags: widths too small");
    end

    typedef struct packed {
        logic [7:0]                  rdata;
        logic                        p1_err;
        logic                        p2_err;
        fault_flags_pkg::port_state_t state;
    } top_state_t;

    top_state_t state_reg;
    top_state_t state_next;

    logic [MV_W:0] margin;
    logic          backbias_cond;
    logic          overcurrent_cond;
    logic          p1_rd;
    logic          p2_rd;
    logic          p1_wr;
    logic          p2_wr;
    logic          p1_err_clear;
    logic          p2_err_clear;
    logic          port1_backbias_flag;
    logic          port1_overcurrent_flag;
    logic          port2_discharge_fault;
    logic          port2_min_voltage_fault;
    logic          thermal_regulation_flag;
    logic          port2_backbias_flag;
    logic          port2_overcurrent_flag;
    logic [7:0]    p1_view;
    logic [7:0]    p2_view;
    logic          p1_any;
    logic          p2_any;

    assign margin = (MV_W+1)'(fault_flags_pkg::BACKBIAS_MARGIN_MV);

    // raw fault conditions of port 1
    assign backbias_cond = ({1'b0, port1_bus_mv} > ({1'b0, source_mv} + margin))
                         | ({1'b0, port1_bus_mv} > ({1'b0, device_mv} + margin));
    assign overcurrent_cond = (port1_current_ma > programmed_current_limit)
                            & (port1_current_ma > secondary_min_current_threshold);

    // register access decode
    assign p1_rd = reg_rd & (reg_addr == fault_flags_pkg::PORT1_STATUS_OFFSET);
    assign p2_rd = reg_rd & (reg_addr == fault_flags_pkg::PORT2_STATUS_OFFSET);
    assign p1_wr = reg_wr & (reg_addr == fault_flags_pkg::PORT1_STATUS_OFFSET);
    assign p2_wr = reg_wr & (reg_addr == fault_flags_pkg::PORT2_STATUS_OFFSET);
    assign p1_err_clear = p1_wr & ~reg_wdata[fault_flags_pkg::P1_ERROR_BIT];
    assign p2_err_clear = p2_wr & ~reg_wdata[fault_flags_pkg::P2_ERROR_BIT];

    // port 1 sticky flags
    sticky_fault_bit u_p1_backbias (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .fault_cond  (backbias_cond),
        .read_clear  (p1_rd),
        .error_clear (p1_err_clear),
        .flag        (port1_backbias_flag)
    );
    sticky_fault_bit u_p1_overcurrent (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .fault_cond  (overcurrent_cond),
        .read_clear  (p1_rd),
        .error_clear (p1_err_clear),
        .flag        (port1_overcurrent_flag)
    );

    // port 2 clear-on-read flags
    sticky_fault_bit u_p2_discharge (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .fault_cond  (port2_discharge_cond),
        .read_clear  (p2_rd),
        .error_clear (p2_err_clear),
        .flag        (port2_discharge_fault)
    );
    sticky_fault_bit u_p2_minvolt (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .fault_cond  (port2_min_voltage_cond),
        .read_clear  (p2_rd),
        .error_clear (p2_err_clear),
        .flag        (port2_min_voltage_fault)
    );
    sticky_fault_bit u_p2_thermal (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .fault_cond  (thermal_regulation_cond),
        .read_clear  (p2_rd),
        .error_clear (1'b0),
        .flag        (thermal_regulation_flag)
    );
    sticky_fault_bit u_p2_backbias (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .fault_cond  (port2_backbias_cond),
        .read_clear  (p2_rd),
        .error_clear (p2_err_clear),
        .flag        (port2_backbias_flag)
    );
    sticky_fault_bit u_p2_overcurrent (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .fault_cond  (port2_overcurrent_cond),
        .read_clear  (p2_rd),
        .error_clear (p2_err_clear),
        .flag        (port2_overcurrent_flag)
    );

    // read views of both registers
    always_comb
    begin
        p1_view = fault_flags_pkg::STATUS_RESET;
        p1_view[fault_flags_pkg::P1_ERROR_BIT]    = state_reg.p1_err;
        p1_view[fault_flags_pkg::P1_BACKBIAS_BIT] = port1_backbias_flag;
        p1_view[fault_flags_pkg::P1_OVERCURR_BIT] = port1_overcurrent_flag;
        p2_view = fault_flags_pkg::STATUS_RESET;  // bit 2 stays zero
        p2_view[fault_flags_pkg::P2_ERROR_BIT]     = state_reg.p2_err;
        p2_view[fault_flags_pkg::P2_DISCHARGE_BIT] = port2_discharge_fault;
        p2_view[fault_flags_pkg::P2_UNDERVOLT_BIT] = source_undervoltage_flag;
        p2_view[fault_flags_pkg::P2_MINVOLT_BIT]   = port2_min_voltage_fault;
        p2_view[fault_flags_pkg::P2_THERMAL_BIT]   = thermal_regulation_flag;
        p2_view[fault_flags_pkg::P2_BACKBIAS_BIT]  = port2_backbias_flag;
        p2_view[fault_flags_pkg::P2_OVERCURR_BIT]  = port2_overcurrent_flag;
    end

    assign p1_any = backbias_cond | overcurrent_cond;
    assign p2_any = port2_discharge_cond | port2_min_voltage_cond
                  | port2_backbias_cond | port2_overcurrent_cond;

    // read data, error flags and error state; live faults beat a clearing write
    always_comb
    begin
        state_next = state_reg;
        if (p1_rd)
            state_next.rdata = p1_view;
        else if (p2_rd)
            state_next.rdata = p2_view;
        else if (reg_rd)
            state_next.rdata = 8'h00;
        if (p1_wr)
            state_next.p1_err = reg_wdata[fault_flags_pkg::P1_ERROR_BIT];
        if (p1_any)
            state_next.p1_err = 1'b1;
        if (p2_wr)
            state_next.p2_err = reg_wdata[fault_flags_pkg::P2_ERROR_BIT];
        if (p2_any)
            state_next.p2_err = 1'b1;
        case (state_reg.state)
            fault_flags_pkg::ST_ACTIVE:
                if (p1_any)
                    state_next.state = fault_flags_pkg::ST_ERROR;
            fault_flags_pkg::ST_ERROR:
                if (p1_err_clear && !p1_any)
                    state_next.state = fault_flags_pkg::ST_ACTIVE;
            default:
                state_next.state = fault_flags_pkg::ST_ACTIVE;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg.rdata  <= fault_flags_pkg::STATUS_RESET;
            state_reg.p1_err <= 1'b0;
            state_reg.p2_err <= 1'b0;
            state_reg.state  <= fault_flags_pkg::ST_ACTIVE;
        end
        else
            state_reg <= state_next;
    end

    // outputs; alerts follow the flags except the thermal and undervoltage flags, not the error bits
    assign reg_rdata        = state_reg.rdata;
    assign port1_alert_n    = ~(port1_backbias_flag | port1_overcurrent_flag);
    assign port2_alert_n    = ~(port2_discharge_fault | port2_min_voltage_fault
                              | port2_backbias_flag | port2_overcurrent_flag);
    assign port1_error_flag = state_reg.p1_err;
    assign port2_error_flag = state_reg.p2_err;
    assign port1_in_error   = (state_reg.state == fault_flags_pkg::ST_ERROR);

    // checks
    a_backbias_sets_flag:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        backbias_cond |=> port1_backbias_flag)
        else $error("back-bias condition did not set flag");
    a_backbias_needs_cond:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(port1_backbias_flag) |-> $past(backbias_cond))
        else $error("back-bias flag rose without condition");
    a_overcurrent_both_limits:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(port1_overcurrent_flag) |-> $past(port1_current_ma > programmed_current_limit)
            && $past(port1_current_ma > secondary_min_current_threshold))
        else $error("overcurrent flag rose without both limits exceeded");
    a_read_clears_flags:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        p1_rd && !backbias_cond && !overcurrent_cond
            |=> !port1_backbias_flag && !port1_overcurrent_flag)
        else $error("read did not clear port 1 flags");
    a_error_clear_flags:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        p1_err_clear && !p1_any |=> !port1_backbias_flag && !port1_error_flag
            && !port1_in_error)
        else $error("error clear did not clear port 1 flags");
    a_flag_enters_error:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        (port1_backbias_flag || port1_overcurrent_flag)
            |-> !port1_alert_n && port1_in_error && port1_error_flag)
        else $error("port 1 flag without alert or error state");
    a_alert_releases:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        !port1_backbias_flag && !port1_overcurrent_flag |-> port1_alert_n)
        else $error("port 1 alert held without a flag");
    a_p2_reserved_zero:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        p2_rd |=> reg_rdata[2] == 1'b0
            && reg_rdata[fault_flags_pkg::P2_UNDERVOLT_BIT] == $past(source_undervoltage_flag))
        else $error("port 2 read shows bad reserved or undervoltage bit");
endmodule
`default_nettype wire

// ===== verif/reg_host.sv
// host model issuing register reads and writes on the strobe port
`timescale 1ns/1ps
`default_nettype none
module reg_host (
    input  wire logic       clk_sys,
    output logic [7:0]      reg_addr,
    output logic            reg_rd,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // idle bus at time zero
    initial
    begin
        reg_addr  = 8'h00;
        reg_rd    = 1'b0;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
    end
    // one-cycle read strobe; released lines show the inverted last value
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_sys);
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(negedge clk_sys);
        reg_rd   = 1'b0;
        data     = reg_rdata;
        reg_addr = ~addr;
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
        reg_addr  = ~addr;
        reg_wdata = ~data;
    endtask
endmodule
`default_nettype wire

// ===== verif/port_fault_status_flags_tb.sv
// self-checking bench for the port fault status flag registers
`timescale 1ns/1ps
`default_nettype none
module port_fault_status_flags_tb;
    logic        clk_sys;
    logic        sys_rst;
    logic [7:0]  reg_addr;
    logic        reg_rd;
    logic        reg_wr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [12:0] bus_mv, src_mv, dev_mv, cur_ma, lim_ma, min_ma;
    logic [5:0]  p2c;
    logic        p1_alert_n, p2_alert_n, p1_err, p2_err, p1_in_err;
    int          fails, n_compared, cycles;
    // overcurrent cases: limit, minimum threshold, current
    logic [12:0] oc_tab [5][3] = '{'{13'h03E8, 13'h05DC, 13'h04B0},
        '{13'h03E8, 13'h05DC, 13'h05DC}, '{13'h03E8, 13'h05DC, 13'h05DD},
        '{13'h05DC, 13'h03E8, 13'h04B0}, '{13'h05DC, 13'h03E8, 13'h05DD}};
    logic [4:0]  oc_exp = 5'h14;

    port_fault_status_flags DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .port1_bus_mv(bus_mv), .source_mv(src_mv), .device_mv(dev_mv),
        .port1_current_ma(cur_ma), .programmed_current_limit(lim_ma),
        .secondary_min_current_threshold(min_ma), .port2_discharge_cond(p2c[5]),
        .source_undervoltage_flag(p2c[4]), .port2_min_voltage_cond(p2c[3]),
        .thermal_regulation_cond(p2c[2]), .port2_backbias_cond(p2c[1]),
        .port2_overcurrent_cond(p2c[0]), .port1_alert_n(p1_alert_n),
        .port2_alert_n(p2_alert_n), .port1_error_flag(p1_err), .port2_error_flag(p2_err),
        .port1_in_error(p1_in_err));
    reg_host u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // 50 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // read a register and compare it
    task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(addr, d);
        check(d, exp);
    endtask
    // port 1 pins: alert_n, error flag, in_error
    task automatic p1(input logic [7:0] exp);
        check({5'h00, p1_alert_n, p1_err, p1_in_err}, exp);
    endtask
    // closing report
    task automatic give_verdict;
        $display("compared=%0d fails=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            give_verdict();
        end
    end
    // main sequence
    initial
    begin
        sys_rst = 1'b1;
        bus_mv  = 13'h0FA0;
        src_mv  = 13'h1388;
        dev_mv  = 13'h1388;
        cur_ma  = 13'h0000;
        lim_ma  = 13'h03E8;
        min_ma  = 13'h05DC;
        p2c     = 6'h00;
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'b0;
        rdchk(8'h03, 8'h00);
        rdchk(8'h04, 8'h00);
        p1(8'h04);
        // back-bias exactly at the margin, then one above
        bus_mv = 13'h141E;
        @(negedge clk_sys);
        p1(8'h04);
        bus_mv = 13'h141F;
        @(negedge clk_sys);
        p1(8'h03);
        rdchk(8'h03, 8'h82);
        rdchk(8'h03, 8'h82);
        bus_mv = 13'h0FA0;
        @(negedge clk_sys);
        p1(8'h03);
        rdchk(8'h03, 8'h82);
        p1(8'h07);
        rdchk(8'h03, 8'h80);
        u_host.wr(8'h03, 8'h00);
        p1(8'h04);
        // device-supply path; error clear while live, then once gone
        dev_mv = 13'h0FA0;
        bus_mv = 13'h1037;
        @(negedge clk_sys);
        rdchk(8'h03, 8'h82);
        u_host.wr(8'h03, 8'h00);
        p1(8'h03);
        bus_mv = 13'h0FA0;
        u_host.wr(8'h03, 8'h00);
        p1(8'h04);
        rdchk(8'h03, 8'h00);
        dev_mv = 13'h1388;
        // overcurrent needs both thresholds exceeded
        for (int i = 0; i < 5; i++)
        begin
            lim_ma = oc_tab[i][0];
            min_ma = oc_tab[i][1];
            cur_ma = oc_tab[i][2];
            @(negedge clk_sys);
            rdchk(8'h03, oc_exp[i] ? 8'h81 : 8'h00);
            cur_ma = 13'h0000;
            u_host.wr(8'h03, 8'h00);
            rdchk(8'h03, 8'h00);
        end
        // error flag written without any alert
        u_host.wr(8'h03, 8'h80);
        check({7'h00, p1_alert_n}, 8'h01);
        rdchk(8'h03, 8'h80);
        u_host.wr(8'h03, 8'h00);
        // port 2 layout, live undervoltage, clear on read
        p2c = 6'h3F;
        @(negedge clk_sys);
        check({7'h00, p2_alert_n}, 8'h00);
        rdchk(8'h04, 8'hFB);
        p2c = 6'h00;
        @(negedge clk_sys);
        rdchk(8'h04, 8'hDB);
        rdchk(8'h04, 8'h80);
        check({6'h00, p2_alert_n, p2_err}, 8'h03);
        u_host.wr(8'h10, 8'hFF);
        rdchk(8'h10, 8'h00);
        u_host.wr(8'h04, 8'hFF);
        rdchk(8'h04, 8'h80);
        u_host.wr(8'h04, 8'h00);
        rdchk(8'h04, 8'h00);
        // reset in mid-run with a flag set
        bus_mv = 13'h141F;
        @(negedge clk_sys);
        sys_rst = 1'b1;
        bus_mv  = 13'h0FA0;
        @(negedge clk_sys);
        sys_rst = 1'b0;
        p1(8'h04);
        rdchk(8'h03, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
